// ---- iop_defs.svh ----
// Register offsets, field positions, reset values for the three-port I/O block.
`ifndef IOP_DEFS_SVH
`define IOP_DEFS_SVH
// ==========================================================================
// Register byte offsets on the bus.
`define IOP_OFS_P3_DIR 8'h00
`define IOP_OFS_P3_DATA 8'h04
`define IOP_OFS_P3_PULL 8'h08
`define IOP_OFS_P4_DIR 8'h0C
`define IOP_OFS_P4_DATA 8'h10
`define IOP_OFS_P4_PULL 8'h14
`define IOP_OFS_P5_DIR 8'h18
`define IOP_OFS_P5_DATA 8'h1C
`define IOP_OFS_MODE 8'h20
`define IOP_OFS_PERIPH 8'h24
`define IOP_OFS_IRQ_SEL 8'h28
`define IOP_OFS_IRQ_EN 8'h2C
`define IOP_OFS_STANDBY 8'h30
// ==========================================================================
// Reset values.
`define IOP_RST_BYTE 8'h00
// ==========================================================================
// Mode register fields.
`define IOP_MODE_EXP 0
`define IOP_MODE_MUX 1
// Standby register field.
`define IOP_STBY_HW 0
// Peripheral enable register fields.
`define IOP_PER_PWM_A 0
`define IOP_PER_PWM_B 1
`define IOP_PER_C_RE 2
`define IOP_PER_C_TE 3
`define IOP_PER_C_SC 4
`define IOP_PER_A_RE 5
`define IOP_PER_A_TE 6
`define IOP_PER_A_SC 7
`define IOP_PER_FIFO 8
`endif

// ---- iop_pkg.sv ----
// Types shared by the three-port I/O block.
package iop_pkg;
	// Operating mode of the first port, decoded from the mode register.
	typedef enum logic [1:0] {
		IOP_SINGLE,
		IOP_NORMAL_EXP,
		IOP_MUXED_EXP
	} iop_mode_e;
	// One byte of port state.
	typedef logic [7:0] iop_byte_t;
endpackage

// ---- iop_ports.sv ----
// Three 8-bit general I/O ports with pin multiplexing behind an AHB-Lite slave.
//
// Contract
// RQ1 - Normal expanded: first port is data bus.
// RQ2 - Other modes: first port direction bit selects.
// RQ3 - Normal expanded: first port pull-ups always off.
// RQ4 - First port pull-up: input and enable only.
// RQ5 - Irq port regs survive watchdog internal reset.
// RQ6 - Irq port direction write-only, resets zero.
// RQ7 - Irq port read: output bit or pin.
// RQ8 - Irq port pull-up: input and enable set.
// RQ9 - Irq port pin feeds external irq line.
// RQ10 - Software clears direction for irq input use.
// RQ11 - Third port direction bit selects pin direction.
// RQ12 - Third port read: output bit or pin.
// RQ13 - Pin 7 drives second pwm when enabled.
// RQ14 - Pin 6 drives first pwm when enabled.
// RQ15 - Pin 5 channel C receive, smart-card bidirectional.
// RQ16 - Pin 4 channel C transmit without smart-card.
// RQ17 - Pin 3 channel A receive, smart-card bidirectional.
// RQ18 - Pin 2 channel A transmit without smart-card.
// RQ19 - Pin 1 fifo serial receive when enabled.
// RQ20 - Pin 0 fifo serial transmit when enabled.
// RQ21 - Pin k feeds irq line 8+k.
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`include "iop_defs.svh"
module iop_ports
	import iop_pkg::*;
(
	// Clock, system reset and the watchdog's internal reset.
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic wdt_reset,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// First port pins and external data bus side.
	input wire logic [7:0] p3_pin_in,
	output logic [7:0] p3_pin_out,
	output logic [7:0] p3_pin_oe_n,
	output logic [7:0] p3_pullup_on,
	input wire logic [7:0] data_bus_out,
	input wire logic data_bus_drive,
	output logic [7:0] data_bus_in,
	// Interrupt port pins.
	input wire logic [7:0] p4_pin_in,
	output logic [7:0] p4_pin_out,
	output logic [7:0] p4_pin_oe_n,
	output logic [7:0] p4_pullup_on,
	// Third port pins.
	input wire logic [7:0] p5_pin_in,
	output logic [7:0] p5_pin_out,
	output logic [7:0] p5_pin_oe_n,
	// Peripheral signals sharing the third port.
	input wire logic pwm_out_first,
	input wire logic pwm_out_second,
	input wire logic chan_c_transmit_pin,
	input wire logic chan_c_rx_drive,
	input wire logic chan_a_transmit_pin,
	input wire logic chan_a_rx_drive,
	input wire logic fifo_serial_transmit_pin,
	output logic chan_c_receive_pin,
	output logic chan_a_receive_pin,
	output logic fifo_serial_receive_pin,
	// External interrupt lines, levels as seen on the pins.
	output logic [15:0] external_irq_line
);

	// ======================================================================
	// Pin synchronisers.
	// Every pin passes two flops; only the second stage is ever read.
	logic [7:0] p3_meta, p3_sync;
	logic [7:0] p4_meta, p4_sync;
	logic [7:0] p5_meta, p5_sync;

	// Two-stage synchronisers for the three pin groups.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p3_meta <= `IOP_RST_BYTE;
			p3_sync <= `IOP_RST_BYTE;
			p4_meta <= `IOP_RST_BYTE;
			p4_sync <= `IOP_RST_BYTE;
			p5_meta <= `IOP_RST_BYTE;
			p5_sync <= `IOP_RST_BYTE;
		end else begin
			p3_meta <= p3_pin_in;
			p3_sync <= p3_meta;
			p4_meta <= p4_pin_in;
			p4_sync <= p4_meta;
			p5_meta <= p5_pin_in;
			p5_sync <= p5_meta;
		end
	end

	// ======================================================================
	// Registers.
	iop_byte_t first_port_dir_bit; // First port direction, write-only.
	iop_byte_t p3_data; // First port output data.
	iop_byte_t first_port_pullup_reg; // First port pull-up enables.
	iop_byte_t irq_port_direction_reg; // Interrupt port direction.
	iop_byte_t irq_port_data_reg; // Interrupt port output data.
	iop_byte_t irq_port_pullup_reg; // Interrupt port pull-up enables.
	iop_byte_t third_port_direction_reg; // Third port direction.
	iop_byte_t third_port_data_reg; // Third port output data.
	logic [1:0] mode_bits; // Expansion select and muxed bus select.
	logic [8:0] periph_en; // Peripheral enables that steal pins.
	logic [15:0] irq_source_select; // Low byte, then the high bank.
	logic [15:0] irq_enable; // Low byte, then the high bank.
	logic hw_standby; // Hardware standby indication.

	// ======================================================================
	// Bus address phase capture.
	logic wr_pend; // A write data phase follows.
	logic [7:0] wr_addr; // Its byte address.

	// Function: true when an address phase selects this slave.
	function automatic logic ahb_go(input logic s, input logic [1:0] t,
		input logic r);
		ahb_go = s && t[1] && r;
	endfunction

	// The slave never stalls, so every access completes in one data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= ahb_go(hsel, htrans, hready) && hwrite;
			wr_addr <= haddr;
		end
	end

	// Response is always OKAY with zero wait states.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ======================================================================
	// Registers cleared by any reset: first and third ports and controls.
	// The watchdog's internal reset clears these as a system reset does.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_port_dir_bit <= `IOP_RST_BYTE;
			p3_data <= `IOP_RST_BYTE;
			first_port_pullup_reg <= `IOP_RST_BYTE;
			third_port_direction_reg <= `IOP_RST_BYTE; // RQ11
			third_port_data_reg <= `IOP_RST_BYTE;
			mode_bits <= 2'h0;
			periph_en <= 9'h000;
			irq_source_select <= 16'h0000;
			irq_enable <= 16'h0000;
			hw_standby <= 1'b0;
		end else if (wdt_reset) begin
			first_port_dir_bit <= `IOP_RST_BYTE;
			p3_data <= `IOP_RST_BYTE;
			first_port_pullup_reg <= `IOP_RST_BYTE;
			third_port_direction_reg <= `IOP_RST_BYTE; // RQ11
			third_port_data_reg <= `IOP_RST_BYTE;
			mode_bits <= 2'h0;
			periph_en <= 9'h000;
			irq_source_select <= 16'h0000;
			irq_enable <= 16'h0000;
			hw_standby <= 1'b0;
		end else if (wr_pend) begin
			case (wr_addr)
				`IOP_OFS_P3_DIR: first_port_dir_bit <= hwdata[7:0];
				`IOP_OFS_P3_DATA: p3_data <= hwdata[7:0];
				`IOP_OFS_P3_PULL: first_port_pullup_reg <= hwdata[7:0];
				`IOP_OFS_P5_DIR: third_port_direction_reg <= hwdata[7:0];
				`IOP_OFS_P5_DATA: third_port_data_reg <= hwdata[7:0];
				`IOP_OFS_MODE: mode_bits <= hwdata[1:0];
				`IOP_OFS_PERIPH: periph_en <= hwdata[8:0];
				`IOP_OFS_IRQ_SEL: irq_source_select <= hwdata[15:0];
				`IOP_OFS_IRQ_EN: irq_enable <= hwdata[15:0];
				`IOP_OFS_STANDBY: hw_standby <= hwdata[`IOP_STBY_HW];
				default: begin
				end
			endcase
		end
	end

	// Interrupt port registers: cleared by system reset only.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_port_direction_reg <= `IOP_RST_BYTE; // RQ5 RQ6
			irq_port_data_reg <= `IOP_RST_BYTE; // RQ5
			irq_port_pullup_reg <= `IOP_RST_BYTE; // RQ8
		end else if (wr_pend) begin
			case (wr_addr)
				`IOP_OFS_P4_DIR: irq_port_direction_reg <= hwdata[7:0];
				`IOP_OFS_P4_DATA: irq_port_data_reg <= hwdata[7:0];
				`IOP_OFS_P4_PULL: irq_port_pullup_reg <= hwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// ======================================================================
	// Mode decode.
	iop_mode_e mode;

	// Decodes the first port's mode from the two select bits.
	always_comb begin
		case (mode_bits)
			2'b01: mode = IOP_NORMAL_EXP;
			2'b11: mode = IOP_MUXED_EXP;
			default: mode = IOP_SINGLE;
		endcase
	end

	// Function: general port read, stored bit where output, pin otherwise.
	function automatic iop_byte_t port_read(input iop_byte_t dir,
		input iop_byte_t dat, input iop_byte_t pin);
		port_read = (dir & dat) | (~dir & pin);
	endfunction

	// ======================================================================
	// Third port pin function selection.
	iop_byte_t next_p5_out, next_p5_oe_n, p5_owned;
	logic sc_c, sc_a;

	// Peripheral enables override the direction bits pin by pin.
	always_comb begin
		sc_c = periph_en[`IOP_PER_C_SC];
		sc_a = periph_en[`IOP_PER_A_SC];
		next_p5_out = third_port_data_reg;
		next_p5_oe_n = ~third_port_direction_reg; // RQ11
		p5_owned = 8'h00;
		// Pin 7, second PWM output.
		if (periph_en[`IOP_PER_PWM_B]) begin
			next_p5_out[7] = pwm_out_second; // RQ13
			next_p5_oe_n[7] = 1'b0; // RQ13
			p5_owned[7] = 1'b1;
		end
		// Pin 6, first PWM output.
		if (periph_en[`IOP_PER_PWM_A]) begin
			next_p5_out[6] = pwm_out_first; // RQ14
			next_p5_oe_n[6] = 1'b0; // RQ14
			p5_owned[6] = 1'b1;
		end
		// Pin 5, channel C receive; smart-card lets the channel drive it.
		if (periph_en[`IOP_PER_C_RE]) begin
			next_p5_out[5] = 1'b0; // RQ15
			next_p5_oe_n[5] = !(sc_c && chan_c_rx_drive); // RQ15
			p5_owned[5] = 1'b1;
		end
		// Pin 4, channel C transmit only outside smart-card mode.
		if (periph_en[`IOP_PER_C_TE] && !sc_c) begin
			next_p5_out[4] = chan_c_transmit_pin; // RQ16
			next_p5_oe_n[4] = 1'b0; // RQ16
			p5_owned[4] = 1'b1;
		end
		// Pin 3, channel A receive.
		if (periph_en[`IOP_PER_A_RE]) begin
			next_p5_out[3] = 1'b0; // RQ17
			next_p5_oe_n[3] = !(sc_a && chan_a_rx_drive); // RQ17
			p5_owned[3] = 1'b1;
		end
		// Pin 2, channel A transmit.
		if (periph_en[`IOP_PER_A_TE] && !sc_a) begin
			next_p5_out[2] = chan_a_transmit_pin; // RQ18
			next_p5_oe_n[2] = 1'b0; // RQ18
			p5_owned[2] = 1'b1;
		end
		// Pins 1 and 0, the FIFO serial unit.
		if (periph_en[`IOP_PER_FIFO]) begin
			next_p5_oe_n[1] = 1'b1; // RQ19
			next_p5_out[0] = fifo_serial_transmit_pin; // RQ20
			next_p5_oe_n[0] = 1'b0; // RQ20
			p5_owned[1:0] = 2'b11;
		end
	end

	// Third port pins and peripheral receive lines, all registered.
	// The one-cycle output delay is the price of flop-driven pins.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p5_pin_out <= `IOP_RST_BYTE;
			p5_pin_oe_n <= 8'hFF;
			chan_c_receive_pin <= 1'b1;
			chan_a_receive_pin <= 1'b1;
			fifo_serial_receive_pin <= 1'b1;
		end else begin
			p5_pin_out <= next_p5_out;
			p5_pin_oe_n <= next_p5_oe_n;
			chan_c_receive_pin <= p5_sync[5]; // RQ15
			chan_a_receive_pin <= p5_sync[3]; // RQ17
			fifo_serial_receive_pin <= p5_sync[1]; // RQ19
		end
	end

	// ======================================================================
	// First port pins, data bus and pull-ups.
	// Normal expanded mode hands every pin to the data bus.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p3_pin_out <= `IOP_RST_BYTE;
			p3_pin_oe_n <= 8'hFF;
			p3_pullup_on <= `IOP_RST_BYTE;
			data_bus_in <= `IOP_RST_BYTE;
		end else begin
			data_bus_in <= p3_sync;
			if (mode == IOP_NORMAL_EXP) begin
				p3_pin_out <= data_bus_out; // RQ1
				p3_pin_oe_n <= {8{!data_bus_drive}}; // RQ1
				p3_pullup_on <= 8'h00; // RQ3
			end else begin
				p3_pin_out <= p3_data; // RQ2
				p3_pin_oe_n <= ~first_port_dir_bit; // RQ2
				p3_pullup_on <= hw_standby ? 8'h00 :
					(~first_port_dir_bit & first_port_pullup_reg); // RQ4
			end
		end
	end

	// ======================================================================
	// Interrupt port pins and pull-ups.
	// A pin meant as an interrupt input must have its direction bit clear,
	// otherwise the line simply follows the port's own output.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p4_pin_out <= `IOP_RST_BYTE;
			p4_pin_oe_n <= 8'hFF;
			p4_pullup_on <= `IOP_RST_BYTE;
		end else begin
			p4_pin_out <= irq_port_data_reg;
			p4_pin_oe_n <= ~irq_port_direction_reg; // RQ6 RQ10
			p4_pullup_on <= hw_standby ? 8'h00 :
				(~irq_port_direction_reg & irq_port_pullup_reg); // RQ8
		end
	end

	// External interrupt lines, gated by source select and enable.
	// Gated-off lines rest high, the inactive level of a low-true line.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			external_irq_line <= 16'hFFFF;
		end else begin
			external_irq_line[7:0] <= p4_sync |
				irq_source_select[7:0] | ~irq_enable[7:0]; // RQ9
			external_irq_line[15:8] <= p5_sync |
				irq_source_select[15:8] | ~irq_enable[15:8]; // RQ21
		end
	end

	// ======================================================================
	// Read data, driven in the data phase after the address phase.
	iop_byte_t p3_read;
	logic [31:0] next_hrdata;

	// Read mux; write-only direction registers and unmapped words read zero.
	always_comb begin
		p3_read = port_read(first_port_dir_bit, p3_data, p3_sync);
		if (mode == IOP_NORMAL_EXP)
			p3_read = p3_data | ~first_port_dir_bit;
		next_hrdata = 32'h0000_0000;
		case (haddr)
			`IOP_OFS_P3_DATA: next_hrdata[7:0] = p3_read;
			`IOP_OFS_P3_PULL: next_hrdata[7:0] = first_port_pullup_reg;
			`IOP_OFS_P4_DATA: next_hrdata[7:0] = port_read(
				irq_port_direction_reg, irq_port_data_reg, p4_sync); // RQ7
			`IOP_OFS_P4_PULL: next_hrdata[7:0] = irq_port_pullup_reg;
			`IOP_OFS_P5_DATA: next_hrdata[7:0] = port_read(
				third_port_direction_reg, third_port_data_reg,
				p5_sync); // RQ12
			`IOP_OFS_MODE: next_hrdata[1:0] = mode_bits;
			`IOP_OFS_PERIPH: next_hrdata[8:0] = periph_en;
			`IOP_OFS_IRQ_SEL: next_hrdata[15:0] = irq_source_select;
			`IOP_OFS_IRQ_EN: next_hrdata[15:0] = irq_enable;
			`IOP_OFS_STANDBY: next_hrdata[0] = hw_standby;
			default: next_hrdata = 32'h0000_0000;
		endcase
	end

	// Read data is captured at the address phase edge.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ahb_go(hsel, htrans, hready) && !hwrite) begin
			hrdata <= next_hrdata;
		end
	end

	// ======================================================================
	// Assertions.
	normal_bus_pull_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(mode == IOP_NORMAL_EXP) |-> p3_pullup_on == 8'h00) // RQ3
		else $error("First port pull-up on in normal expanded mode.");
	normal_bus_dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(mode == IOP_NORMAL_EXP && !data_bus_drive)
		|-> p3_pin_oe_n == 8'hFF) // RQ1
		else $error("First port driven while bus is not driving.");
	first_dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(mode != IOP_NORMAL_EXP)
		|-> p3_pin_oe_n == ~$past(first_port_dir_bit)) // RQ2
		else $error("First port enable not following direction.");
	first_pull_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(hw_standby) |-> p3_pullup_on == 8'h00) // RQ4
		else $error("First port pull-up on in hardware standby.");
	irq_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wdt_reset && !wr_pend |=> $stable(irq_port_direction_reg)
		&& $stable(irq_port_data_reg)) // RQ5
		else $error("Interrupt port lost contents on watchdog reset.");
	irq_pull_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(p4_pullup_on & $past(irq_port_direction_reg)) == 8'h00) // RQ8
		else $error("Interrupt port pull-up on while an output.");
	pwm_b_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(periph_en[`IOP_PER_PWM_B]) |-> !p5_pin_oe_n[7]
		&& p5_pin_out[7] == $past(pwm_out_second)) // RQ13
		else $error("Pin 7 not driving second pwm output.");
	pwm_a_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(periph_en[`IOP_PER_PWM_A]) |-> !p5_pin_oe_n[6]) // RQ14
		else $error("Pin 6 not driving first pwm output.");
	tx_c_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(periph_en[`IOP_PER_C_SC]) && $past(!periph_en[`IOP_PER_C_RE])
		|-> p5_pin_oe_n[4] == !$past(third_port_direction_reg[4])) // RQ16
		else $error("Pin 4 taken by transmit in smart-card mode.");
	fifo_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(periph_en[`IOP_PER_FIFO]) |-> p5_pin_oe_n[1:0] == 2'b10
		&& p5_pin_out[0] == $past(fifo_serial_transmit_pin)) // RQ19 RQ20
		else $error("Fifo serial pins misdirected.");
	p5_owned_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(p5_owned == 8'h00) |=> p5_pin_oe_n == ~$past(third_port_direction_reg)
		) // RQ11
		else $error("Third port direction not followed.");
	irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!irq_enable[3] |=> external_irq_line[3]) // RQ9
		else $error("Disabled interrupt line went active.");
	irq_hi_a: assert property (@(posedge hclk) disable iff (!hresetn)
		irq_enable[8] && !irq_source_select[8]
		|=> external_irq_line[8] == $past(p5_sync[0])) // RQ21
		else $error("Line 8 not following third port pin 0.");
	read_p5_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ahb_go(hsel, htrans, hready) && !hwrite
		&& haddr == `IOP_OFS_P5_DATA
		|=> hrdata[7:0] == $past(port_read(third_port_direction_reg,
		third_port_data_reg, p5_sync))) // RQ12
		else $error("Third port read value wrong.");
	read_p4_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ahb_go(hsel, htrans, hready) && !hwrite
		&& haddr == `IOP_OFS_P4_DATA
		|=> hrdata[7:0] == $past(port_read(irq_port_direction_reg,
		irq_port_data_reg, p4_sync))) // RQ7
		else $error("Interrupt port read value wrong.");
	cover_normal_c: cover property (@(posedge hclk) disable iff (!hresetn)
		mode == IOP_NORMAL_EXP ##1 data_bus_drive);
	cover_pwm_c: cover property (@(posedge hclk) disable iff (!hresetn)
		periph_en[`IOP_PER_PWM_B] && periph_en[`IOP_PER_PWM_A]);
	cover_sc_c: cover property (@(posedge hclk) disable iff (!hresetn)
		periph_en[`IOP_PER_C_RE] && sc_c && chan_c_rx_drive);
	cover_wdt_c: cover property (@(posedge hclk) disable iff (!hresetn)
		wdt_reset && irq_port_direction_reg != 8'h00);
endmodule

// ---- iop_board.sv ----
// Board model that resolves the three ports' pin levels.
module iop_board (
	// Drive and pull-up state from the port block.
	input wire logic [23:0] pin_out,
	input wire logic [23:0] pin_oe_n,
	input wire logic [23:0] pullup_on,
	// Board drive value and its enable.
	input wire logic [23:0] ext_val,
	input wire logic [23:0] ext_drv,
	// Resolved pin levels fed back to the block.
	output logic [23:0] pin_lvl
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Pin resolution
	// The block wins over the board; a released pin with no
	// pull-up shows the inverse of the last board value, so a
	// floating pin can never read as a lucky match.
	always_comb begin
		for (int k = 0; k < 24; k++) begin
			if (!pin_oe_n[k]) begin
				pin_lvl[k] = pin_out[k];
			end else if (ext_drv[k]) begin
				pin_lvl[k] = ext_val[k];
			end else if (pullup_on[k]) begin
				pin_lvl[k] = 1'b1;
			end else begin
				pin_lvl[k] = ~ext_val[k];
			end
		end
	end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the three-port I/O block.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import iop_pkg::*;
	`include "iop_defs.svh"
	// ==========================================================
	// Signals
	logic hclk = 0, hresetn = 0, wdt_reset = 0, hsel = 0, hwrite = 0;
	logic [7:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic [31:0] hwdata = 0, hrdata;
	logic hready, hresp;
	logic [7:0] p3o, p3e, p3u, p4o, p4e, p4u, p5o, p5e, dbin;
	logic [7:0] dbo = 0;
	logic dbd = 0;
	logic [6:0] per = 0; // Pwm a, pwm b, c tx, c rx drive, a tx, a rx drive, fifo tx.
	logic crx, arx, frx;
	logic [15:0] irq;
	logic [23:0] ext = 0, drv = 24'hFFFFFF, lvl;
	int bad_count = 0, samples_checked = 0;
	always #2.5 hclk = ~hclk;
	// ==========================================================
	// Design and board
	// The single slave's hreadyout is the bus's hready.
	iop_ports iop_ports_i (.hclk(hclk), .hresetn(hresetn),
		.wdt_reset(wdt_reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .p3_pin_in(lvl[7:0]),
		.p3_pin_out(p3o), .p3_pin_oe_n(p3e), .p3_pullup_on(p3u),
		.data_bus_out(dbo), .data_bus_drive(dbd), .data_bus_in(dbin),
		.p4_pin_in(lvl[15:8]), .p4_pin_out(p4o), .p4_pin_oe_n(p4e),
		.p4_pullup_on(p4u), .p5_pin_in(lvl[23:16]), .p5_pin_out(p5o),
		.p5_pin_oe_n(p5e), .pwm_out_first(per[0]),
		.pwm_out_second(per[1]), .chan_c_transmit_pin(per[2]),
		.chan_c_rx_drive(per[3]), .chan_a_transmit_pin(per[4]),
		.chan_a_rx_drive(per[5]), .fifo_serial_transmit_pin(per[6]),
		.chan_c_receive_pin(crx), .chan_a_receive_pin(arx),
		.fifo_serial_receive_pin(frx), .external_irq_line(irq));
	iop_board iop_board_i (.pin_out({p5o, p4o, p3o}),
		.pin_oe_n({p5e, p4e, p3e}), .pullup_on({8'h00, p4u, p3u}),
		.ext_val(ext), .ext_drv(drv), .pin_lvl(lvl));
	// ==========================================================
	// Shared tasks
	task automatic end_sim();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One single AHB-Lite transfer; the wait for hready is bounded.
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge hclk);
		hsel <= 1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		for (int p = 0; p < 2; p++) begin
			n = 0;
			do begin
				@(posedge hclk);
				n++;
			end while (hready !== 1'b1 && n < 50);
			if (n >= 50) begin
				bad_count++;
				$display("FAIL %0t bus hang", $time);
				end_sim();
			end
			q = hrdata;
			htrans <= 2'b00;
			hsel <= 0;
			hwdata <= d;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		chk(q, e);
	endtask
	// Lets register writes reach the pins and pins reach the syncs.
	task automatic settle();
		repeat (5) @(posedge hclk);
		#1;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		rd(`IOP_OFS_P4_DIR, 32'h0);
		rd(`IOP_OFS_P4_PULL, 32'h0);
		rd(8'h3C, 32'h0);
		chk(32'(p4e), 32'hFF);
		chk(32'(p5e), 32'hFF);
		chk(32'({hready, hresp}), 32'h2);
	endtask
	task automatic t_irq_port();
		ext[15:8] <= 8'h3C;
		wr(`IOP_OFS_P4_DIR, 32'h0F);
		wr(`IOP_OFS_P4_DATA, 32'hA5);
		settle();
		chk(32'({p4e, p4o[3:0]}), 32'hF05);
		rd(`IOP_OFS_P4_DATA, 32'h35);
		wr(`IOP_OFS_P4_PULL, 32'hFF);
		drv[15:8] <= 8'h00;
		settle();
		chk(32'(p4u), 32'hF0);
		rd(`IOP_OFS_P4_DATA, 32'hF5);
	endtask
	task automatic t_wdt();
		wr(`IOP_OFS_P5_DIR, 32'hFF);
		@(posedge hclk);
		wdt_reset <= 1;
		@(posedge hclk);
		wdt_reset <= 0;
		settle();
		chk(32'({p4e, p4u}), 32'hF0F0);
		rd(`IOP_OFS_P4_DATA, 32'hF5);
		chk(32'(p5e), 32'hFF);
	endtask
	task automatic t_port3();
		ext[7:0] <= 8'h96;
		wr(`IOP_OFS_P3_DIR, 32'h0F);
		wr(`IOP_OFS_P3_DATA, 32'h5A);
		wr(`IOP_OFS_P3_PULL, 32'hFF);
		settle();
		chk(32'({p3e, p3o[3:0]}), 32'hF0A);
		chk(32'(p3u), 32'hF0);
		wr(`IOP_OFS_MODE, 32'h1);
		dbo <= 8'hC3;
		dbd <= 1;
		settle();
		chk(32'({p3e, p3o, p3u}), 32'h00C300);
		@(posedge hclk);
		dbd <= 0;
		settle();
		chk(32'({p3e, dbin}), 32'hFF96);
		wr(`IOP_OFS_MODE, 32'h3);
		settle();
		chk(32'(p3u), 32'hF0);
		wr(`IOP_OFS_STANDBY, 32'h1);
		settle();
		chk(32'(p3u), 32'h00);
		wr(`IOP_OFS_STANDBY, 32'h0);
		wr(`IOP_OFS_MODE, 32'h0);
	endtask
	// Peripheral enable, expected oe_n and out with direction all 1.
	task automatic t_port5();
		logic [31:0] tab [11] = '{32'h001_00_40, 32'h002_00_80,
			32'h004_20_00, 32'h014_00_00, 32'h008_00_10,
			32'h018_00_00, 32'h020_08_00, 32'h0A0_00_00,
			32'h040_00_04, 32'h0C0_00_00, 32'h100_02_01};
		per <= 7'h7F;
		wr(`IOP_OFS_P5_DIR, 32'hFF);
		wr(`IOP_OFS_P5_DATA, 32'h00);
		foreach (tab[i]) begin
			wr(`IOP_OFS_PERIPH, 32'(tab[i][31:16]));
			settle();
			chk(32'({p5e, p5o}), 32'(tab[i][15:0]));
		end
		@(posedge hclk);
		ext[23:16] <= 8'h22;
		wr(`IOP_OFS_PERIPH, 32'h124);
		wr(`IOP_OFS_P5_DIR, 32'h00);
		settle();
		chk(32'({crx, arx, frx}), 32'h5);
		wr(`IOP_OFS_PERIPH, 32'h0);
		wr(`IOP_OFS_P5_DIR, 32'h0F);
		ext[23:16] <= 8'h90;
		settle();
		chk(32'(p5e), 32'hF0);
		rd(`IOP_OFS_P5_DATA, 32'h90);
	endtask
	task automatic t_irq();
		wr(`IOP_OFS_P4_DIR, 32'h00);
		wr(`IOP_OFS_P5_DIR, 32'h00);
		drv <= 24'hFFFFFF;
		ext[23:8] <= 16'h0001;
		wr(`IOP_OFS_IRQ_SEL, 32'h0100);
		wr(`IOP_OFS_IRQ_EN, 32'h0155);
		settle();
		chk(32'(irq), 32'hFFAB);
		@(posedge hclk);
		ext[23:8] <= 16'h8100;
		wr(`IOP_OFS_IRQ_SEL, 32'h0);
		wr(`IOP_OFS_IRQ_EN, 32'hFF00);
		settle();
		chk(32'(irq), 32'h81FF);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1;
		t_reset();
		t_irq_port();
		t_wdt();
		t_port3();
		t_port5();
		t_irq();
		end_sim();
	end
endmodule
